// ==== verilog/phs_pkg.sv ====
// Package for the port handshake block: field positions, line indices,
// mode codes, reset values and state codes shared by all design files.
// Assumes the consuming modules import the whole package.
`default_nettype none

package phs_pkg;

    // ****************************************************************
    // Control register field positions (same layout for port A and B).
    // ****************************************************************
    localparam int unsigned PHS_IN_MODE_LSB = 0;   // Input-only strobe mode, bits 1:0.
    localparam int unsigned PHS_LATCH_EN_BIT = 2;  // Port A input latch enable.
    localparam int unsigned PHS_BIDIR_MODE_LSB = 3; // Bidirectional strobe mode, bits 4:3.
    localparam int unsigned PHS_LEVEL_BIT = 4;     // Selects static output modes 2 and 3; the level is bit 3.

    // ****************************************************************
    // Port C pins that can serve as handshake lines.
    // ****************************************************************
    localparam int unsigned PHS_PIN_A_INPUT = 4;   // Port A input-only strobe pin.
    localparam int unsigned PHS_PIN_A_BIDIR = 5;   // Port A bidirectional strobe pin.
    localparam int unsigned PHS_PIN_B_INPUT = 6;   // Port B input-only strobe pin.
    localparam int unsigned PHS_PIN_B_BIDIR = 7;   // Port B bidirectional strobe pin.

    // ****************************************************************
    // Handshake line indices, equal to the status and warning bits.
    // ****************************************************************
    localparam int unsigned PHS_LINE_A_IN = 0;     // Port A input status bit.
    localparam int unsigned PHS_LINE_A_BI = 1;     // Port A second status bit.
    localparam int unsigned PHS_LINE_B_IN = 2;     // Port B input status bit.
    localparam int unsigned PHS_LINE_B_BI = 3;     // Port B second status bit.
    localparam int unsigned PHS_NUM_LINES = 4;     // Handshake lines in all.
    localparam int unsigned PHS_IRQ_FLAG_BIT = 7;  // Interrupt flag in the status byte.

    // ****************************************************************
    // Mode codes and reset values.
    // ****************************************************************
    localparam logic [1:0] PHS_MODE_0 = 2'h0;      // Falling edge, or output held till input edge.
    localparam logic [1:0] PHS_MODE_1 = 2'h1;      // Falling edge with irq, or pulse output.
    localparam logic [1:0] PHS_MODE_2 = 2'h2;      // Rising edge, or output held low.
    localparam logic [1:0] PHS_MODE_3 = 2'h3;      // Rising edge with irq, or output held high.
    localparam logic [7:0] PHS_BYTE_RESET = 8'h00; // Reset value of status and warning.
    localparam logic [3:0] PHS_LINES_RESET = 4'h0; // Reset value of per-line flags.
    localparam logic [7:0] PHS_DATA_RESET = 8'h00; // Reset value of data holding flops.

    // Output strobe sequencer states, one-hot.
    typedef enum logic [2:0] {
        PHS_ST_HIGH  = 3'h1,
        PHS_ST_ARMED = 3'h2,
        PHS_ST_LOW   = 3'h4
    } phs_strobe_state_t;

endpackage

`default_nettype wire

// ==== verilog/phs_edge_detect.sv ====
// Active-transition detector for one handshake input line.
// Assumes the line is synchronous to clk.
`timescale 1ns/1ns
`default_nettype none

module phs_edge_detect
    import phs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_in,
    input wire logic enable,
    input wire logic [1:0] mode,
    output logic active
);

    logic prev_q; // Line level at the previous edge.
    logic prev_d; // Next value of prev_q.

    // Modes 0 and 1 take a falling edge, modes 2 and 3 a rising one.
    always_comb begin
        prev_d = line_in;
        if (mode[1]) begin
            active = enable & line_in & ~prev_q;
        end else begin
            active = enable & ~line_in & prev_q;
        end
    end

    // The previous level is tracked even while disabled, so that enabling
    // the line never reports a stale edge.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= prev_d;
        end
    end

endmodule // phs_edge_detect

`default_nettype wire

// ==== verilog/phs_out_strobe.sv ====
// Output strobe sequencer for one bidirectional handshake line.
// Assumes trigger, bus_edge and input_edge are one-cycle pulses on clk.
`timescale 1ns/1ns
`default_nettype none

module phs_out_strobe
    import phs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [1:0] mode,
    input wire logic trigger,
    input wire logic bus_edge,
    input wire logic input_edge,
    output logic strobe_q
);

    phs_strobe_state_t state_q; // Sequencer state.
    phs_strobe_state_t state_d; // Next sequencer state.
    logic strobe_d;             // Next strobe level.

    // Disabled or static modes park in the high state, so a later entry
    // into mode 0 or 1 starts from the default high level.
    always_comb begin
        state_d = state_q;
        if (!enable || mode[1]) begin
            state_d = PHS_ST_HIGH;
        end else begin
            case (state_q)
                PHS_ST_HIGH: begin
                    if (trigger && mode == PHS_MODE_0) begin
                        state_d = PHS_ST_LOW;
                    end else if (trigger) begin
                        state_d = PHS_ST_ARMED;
                    end
                end
                PHS_ST_ARMED: begin
                    if (bus_edge) begin
                        state_d = PHS_ST_LOW;
                    end
                end
                PHS_ST_LOW: begin
                    if (mode == PHS_MODE_0 && input_edge) begin
                        state_d = PHS_ST_HIGH;
                    end else if (mode == PHS_MODE_1 && bus_edge) begin
                        state_d = PHS_ST_HIGH;
                    end
                end
                default: begin
                    state_d = PHS_ST_HIGH;
                end
            endcase
        end
        if (enable && mode == PHS_MODE_2) begin
            strobe_d = 1'b0;
        end else if (enable && mode == PHS_MODE_3) begin
            strobe_d = 1'b1;
        end else begin
            strobe_d = (state_d != PHS_ST_LOW);
        end
    end

    // Registers only.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= PHS_ST_HIGH;
            strobe_q <= 1'b1;
        end else begin
            state_q <= state_d;
            strobe_q <= strobe_d;
        end
    end

endmodule // phs_out_strobe

`default_nettype wire

// ==== verilog/phs_port_handshake.sv ====
// Handshake, status, warning and port A input latch logic of a parallel
// port device with four port C lines usable as strobes.
// Assumes register decoding lives outside: control bytes arrive as levels,
// data register accesses arrive as one-cycle pulses synchronous to clk.
//
// Functional notes
// - Upper port C pins: I/O or handshake.
// - Two strobes per port: input, bidirectional.
// - Direction bits 5 and 7 steer bidirectional strobes.
// - Reset disables handshakes, clears mode fields.
// - Modes 0,1 falling edge; 2,3 rising.
// - Active input transition sets its status bit.
// - Modes 1,3 also set interrupt flag.
// - Interrupt released when enabled status bits clear.
// - Transition with status set sets warning.
// - Warning clears: data access, then warning read.
// - Output modes 2,3 follow control bit 3.
// - Port A strobe low after alternate reads.
// - Port B strobe low after alternate writes.
// - Mode 0: input strobe edge returns high.
// - Mode 1: low pulse one bus cycle, six clocks.
// - Mode 1 timed by address strobe edges.
// - Entering output mode drives default level.
// - Latch enable captures port A pins.
// - Unlatched reads return live pins, output bits.
// - While latched, edges only set warning.
// - Latch released when port A status clears.
// - Interrupt output low while flag set.
// - Alternate access clears status, buffers warning.
`timescale 1ns/1ns
`default_nettype none

module phs_port_handshake
    import phs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // Bus timing and data register access pulses.
    input wire logic address_strobe,
    input wire logic access_write,
    input wire logic port_a_alt_data_one_access,
    input wire logic port_a_alt_data_two_access,
    input wire logic port_b_alt_data_one_access,
    input wire logic port_b_alt_data_two_access,
    input wire logic strobe_warning_read,
    // Configuration bytes.
    input wire logic [7:0] port_c_function_select,
    input wire logic [7:0] port_c_direction,
    input wire logic [7:0] port_a_strobe_control,
    input wire logic [7:0] port_b_strobe_control,
    // Port A data path.
    input wire logic [7:0] port_a_pins,
    input wire logic [7:0] port_a_direction,
    input wire logic [7:0] port_a_output_latch,
    output logic [7:0] port_a_read_data,
    // Handshake pins.
    input wire logic port_a_input_strobe,
    input wire logic port_a_bidir_strobe_i,
    output logic port_a_bidir_strobe_o,
    output logic port_a_bidir_strobe_oe,
    input wire logic port_b_input_strobe,
    input wire logic port_b_bidir_strobe_i,
    output logic port_b_bidir_strobe_o,
    output logic port_b_bidir_strobe_oe,
    // Status and interrupt.
    output logic [7:0] strobe_status,
    output logic [7:0] strobe_warning,
    output logic irq_n_o,
    output logic irq_n_oe
);

    // ****************************************************************
    // Line configuration.
    // ****************************************************************

    logic [3:0] line_level;   // Pin level of each handshake line.
    logic [3:0] line_hs;      // Line is a handshake line, not port C I/O.
    logic [3:0] line_input;   // Line is a handshake line acting as input.
    logic [3:0] line_irq_en;  // Line is an input with interrupts enabled.
    logic [1:0] line_mode [PHS_NUM_LINES]; // Two-bit mode of each line.
    logic [3:0] line_active;  // Active transition seen this cycle.
    logic [3:0] line_access;  // Alternate data register access per line.

    // Mode field of a control byte at a given position.
    function automatic logic [1:0] phs_field(input logic [7:0] ctl, input int unsigned lsb);
        phs_field = ctl[lsb +: 2];
    endfunction

    // Pins, function select and direction feed one flat per-line view.
    // Input-only strobes are always inputs; the bidirectional ones follow
    // port C direction, a one making them outputs.
    always_comb begin
        line_level = {port_b_bidir_strobe_i, port_b_input_strobe,
                      port_a_bidir_strobe_i, port_a_input_strobe};
        line_hs = {port_c_function_select[PHS_PIN_B_BIDIR],
                   port_c_function_select[PHS_PIN_B_INPUT],
                   port_c_function_select[PHS_PIN_A_BIDIR],
                   port_c_function_select[PHS_PIN_A_INPUT]};
        line_input = line_hs & {~port_c_direction[PHS_PIN_B_BIDIR], 1'b1,
                                ~port_c_direction[PHS_PIN_A_BIDIR], 1'b1};
        line_mode[PHS_LINE_A_IN] = phs_field(port_a_strobe_control, PHS_IN_MODE_LSB);
        line_mode[PHS_LINE_A_BI] = phs_field(port_a_strobe_control, PHS_BIDIR_MODE_LSB);
        line_mode[PHS_LINE_B_IN] = phs_field(port_b_strobe_control, PHS_IN_MODE_LSB);
        line_mode[PHS_LINE_B_BI] = phs_field(port_b_strobe_control, PHS_BIDIR_MODE_LSB);
        line_access = {port_b_alt_data_two_access, port_b_alt_data_one_access,
                       port_a_alt_data_two_access, port_a_alt_data_one_access};
    end

    // ****************************************************************
    // Edge detection, one detector per handshake line.
    // ****************************************************************

    // A line only reports edges while it is an input handshake line, so
    // port C I/O traffic never disturbs the status byte.
    genvar gi;
    generate
        for (gi = 0; gi < PHS_NUM_LINES; gi++) begin : g_edge
            phs_edge_detect u_edge (
                .clk(clk),
                .rst_n(rst_n),
                .line_in(line_level[gi]),
                .enable(line_input[gi]),
                .mode(line_mode[gi]),
                .active(line_active[gi])
            );
            assign line_irq_en[gi] = line_input[gi] & line_mode[gi][0];
        end
    endgenerate

    // ****************************************************************
    // Address strobe edges.
    // ****************************************************************

    logic as_prev_q;  // Address strobe at the previous edge.
    logic as_prev_d;  // Next value of as_prev_q.
    logic as_rise;    // Rising address strobe, paces port A.
    logic as_fall;    // Falling address strobe, paces port B.

    // Each bus cycle is bounded by address strobe pulses, so the strobe
    // edges are the only time base the pulse mode uses.
    always_comb begin
        as_prev_d = address_strobe;
        as_rise = address_strobe & ~as_prev_q;
        as_fall = ~address_strobe & as_prev_q;
    end

    // Registers only.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            as_prev_q <= 1'b0;
        end else begin
            as_prev_q <= as_prev_d;
        end
    end

    // ****************************************************************
    // Status, warning and interrupt flag.
    // ****************************************************************

    logic [3:0] status_q;     // Per-line status bits.
    logic [3:0] status_d;     // Next status bits.
    logic [3:0] warn_q;       // Per-line warning bits.
    logic [3:0] warn_d;       // Next warning bits.
    logic [3:0] warn_buf_q;   // Warnings armed for clearing by an access.
    logic [3:0] warn_buf_d;   // Next armed warnings.
    logic irq_flag_q;         // Interrupt flag.
    logic irq_flag_d;         // Next interrupt flag.

    // A set and a clear in the same cycle leave the bit set, so an edge is
    // never lost to a concurrent access. A warning is only dropped when an
    // access has first buffered it and a warning read follows; a fresh
    // overrun in the read cycle survives.
    always_comb begin
        status_d = (status_q & ~line_access) | line_active;
        warn_buf_d = warn_buf_q | (line_access & warn_q);
        warn_d = warn_q;
        if (strobe_warning_read) begin
            warn_d = warn_q & ~warn_buf_q;
            warn_buf_d = line_access & warn_q;
        end
        warn_d = warn_d | (line_active & status_q);
        // The flag follows the enabled status bits, so it falls only once
        // every enabled line has been serviced.
        irq_flag_d = |(status_d & line_irq_en);
    end

    // Registers only; reset clears all flags.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q <= PHS_LINES_RESET;
            warn_q <= PHS_LINES_RESET;
            warn_buf_q <= PHS_LINES_RESET;
            irq_flag_q <= 1'b0;
        end else begin
            status_q <= status_d;
            warn_q <= warn_d;
            warn_buf_q <= warn_buf_d;
            irq_flag_q <= irq_flag_d;
        end
    end

    // Status and warning bytes as software sees them.
    always_comb begin
        strobe_status = PHS_BYTE_RESET;
        strobe_status[3:0] = status_q;
        strobe_status[PHS_IRQ_FLAG_BIT] = irq_flag_q;
        strobe_warning = PHS_BYTE_RESET;
        strobe_warning[3:0] = warn_q;
    end

    // Open-drain request: the pin is pulled low while the flag stands and
    // released to the pull-up otherwise.
    always_comb begin
        irq_n_o = 1'b0;
        irq_n_oe = irq_flag_q;
    end

    // ****************************************************************
    // Port A input latch.
    // ****************************************************************

    logic [7:0] latch_q;      // Captured port A pins.
    logic [7:0] latch_d;      // Next captured value.
    logic [7:0] rdata_q;      // Registered port A read data.
    logic [7:0] rdata_d;      // Next read data.
    logic latch_en;           // Latch feature enabled.
    logic latch_held;         // Captured data currently presented.

    // Capture happens only on an edge that finds the status clear, so a
    // later edge while latched leaves the data alone and only warns.
    always_comb begin
        latch_en = port_a_strobe_control[PHS_LATCH_EN_BIT];
        latch_held = latch_en & status_q[PHS_LINE_A_IN];
        latch_d = latch_q;
        if (latch_en && line_active[PHS_LINE_A_IN] && !status_q[PHS_LINE_A_IN]) begin
            latch_d = port_a_pins;
        end
        if (latch_held) begin
            rdata_d = (latch_q & ~port_a_direction)
                    | (port_a_output_latch & port_a_direction);
        end else begin
            rdata_d = (port_a_pins & ~port_a_direction)
                    | (port_a_output_latch & port_a_direction);
        end
    end

    // Registers only. The read path lags the pins by one clock, which is
    // well inside a bus cycle at this clock rate.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_q <= PHS_DATA_RESET;
            rdata_q <= PHS_DATA_RESET;
        end else begin
            latch_q <= latch_d;
            rdata_q <= rdata_d;
        end
    end

    assign port_a_read_data = rdata_q;

    // ****************************************************************
    // Output strobes.
    // ****************************************************************

    logic trig_a;   // Port A strobe request from a read.
    logic trig_b;   // Port B strobe request from a write.
    logic bidir_out_a; // Port A bidirectional strobe drives the pin.
    logic bidir_out_b; // Port B bidirectional strobe drives the pin.

    // Port A favours input: reads start its strobe. Port B favours output:
    // writes start its strobe. The second alternate register only counts
    // while the input status is clear.
    always_comb begin
        trig_a = !access_write && (port_a_alt_data_one_access
                 || (port_a_alt_data_two_access && !status_q[PHS_LINE_A_IN]));
        trig_b = access_write && (port_b_alt_data_one_access
                 || (port_b_alt_data_two_access && !status_q[PHS_LINE_B_IN]));
        bidir_out_a = line_hs[PHS_LINE_A_BI] & port_c_direction[PHS_PIN_A_BIDIR];
        bidir_out_b = line_hs[PHS_LINE_B_BI] & port_c_direction[PHS_PIN_B_BIDIR];
        port_a_bidir_strobe_oe = bidir_out_a;
        port_b_bidir_strobe_oe = bidir_out_b;
    end

    // Port A strobe, paced by rising address strobe edges in pulse mode.
    phs_out_strobe u_strobe_a (
        .clk(clk),
        .rst_n(rst_n),
        .enable(bidir_out_a),
        .mode(line_mode[PHS_LINE_A_BI]),
        .trigger(trig_a),
        .bus_edge(as_rise),
        .input_edge(line_active[PHS_LINE_A_IN]),
        .strobe_q(port_a_bidir_strobe_o)
    );

    // Port B strobe, paced by falling address strobe edges in pulse mode.
    phs_out_strobe u_strobe_b (
        .clk(clk),
        .rst_n(rst_n),
        .enable(bidir_out_b),
        .mode(line_mode[PHS_LINE_B_BI]),
        .trigger(trig_b),
        .bus_edge(as_fall),
        .input_edge(line_active[PHS_LINE_B_IN]),
        .strobe_q(port_b_bidir_strobe_o)
    );

endmodule // phs_port_handshake

`default_nettype wire

// ==== tb/phs_peer.sv ====
// Strobed peripheral: drives one input-only strobe line of the block.
// Assumes the bench clock and the bidir strobe drive level of its port.
`timescale 1ns/1ns
`default_nettype none
module phs_peer (
    input wire logic clk,
    input wire logic go,
    input wire logic req_n,
    input wire logic idle,
    output logic line
);
    int cnt = 0; // Cycles left in the strobe pulse.
    // A pulse starts on a bench request, or as the answer to a low bidir strobe.
    always @(posedge clk) begin
        if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (go || !req_n) begin
            cnt <= 2;
        end
    end
    // The idle level picks which edge of the pulse is the active one.
    assign line = idle ^ (cnt > 0);
endmodule // phs_peer
`default_nettype wire

// ==== tb/phs_check_monitor.sv ====
// Port assertions for the handshake block.
// Assumes control bytes are zero while reset is held.
`timescale 1ns/1ns
`default_nettype none
module phs_check_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic access_write,
    input wire logic port_a_alt_data_one_access,
    input wire logic strobe_warning_read,
    input wire logic [7:0] port_c_function_select,
    input wire logic [7:0] port_a_strobe_control,
    input wire logic [7:0] port_b_strobe_control,
    input wire logic port_a_input_strobe,
    input wire logic port_a_bidir_strobe_o,
    input wire logic port_a_bidir_strobe_oe,
    input wire logic port_b_bidir_strobe_o,
    input wire logic port_b_bidir_strobe_oe,
    input wire logic [7:0] strobe_status,
    input wire logic [7:0] strobe_warning,
    input wire logic irq_n_o,
    input wire logic irq_n_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Port A input line enabled with a falling active edge.
    wire logic fsa = port_c_function_select[4] && !port_a_strobe_control[1];
    // Port A bidir line driven in output mode 0.
    wire logic m0a = port_a_bidir_strobe_oe && port_a_strobe_control[4:3] == 2'h0;
    irq_pin_a:
        assert property (!irq_n_o && irq_n_oe == strobe_status[7]) else $error("irq pin");
    irq_src_a:
        assert property (strobe_status[7] |-> |strobe_status[3:0]) else $error("irq src");
    stat_set_a:
        assert property (fsa && $fell(port_a_input_strobe) |=> strobe_status[0])
        else $error("status set");
    warn_set_a:
        assert property (fsa && strobe_status[0] && $fell(port_a_input_strobe)
        && !port_a_alt_data_one_access |=> strobe_warning[0]) else $error("warn set");
    warn_hold_a:
        assert property (strobe_warning[0] && !strobe_warning_read |=> strobe_warning[0])
        else $error("warn hold");
    level_b_a:
        assert property (port_b_bidir_strobe_oe && port_b_strobe_control[4]
        && $stable(port_b_strobe_control) |-> port_b_bidir_strobe_o == port_b_strobe_control[3])
        else $error("level");
    low_a_a:
        assert property (m0a && $stable(port_a_strobe_control) && port_a_alt_data_one_access
        && !access_write && $stable(port_a_input_strobe) |=> !port_a_bidir_strobe_o)
        else $error("strobe low");
    high_a_a:
        assert property (m0a && $stable(port_a_strobe_control) && fsa
        && $fell(port_a_input_strobe) |=> port_a_bidir_strobe_o) else $error("strobe high");
endmodule // phs_check_monitor
bind phs_port_handshake phs_check_monitor u_mon (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the port handshake block with two peripherals.
// Assumes the package, design, peer and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 0, rst_n = 0, address_strobe = 0, access_write = 0, go_a = 0, go_b = 0;
    logic port_a_alt_data_one_access = 0, port_a_alt_data_two_access = 0;
    logic port_b_alt_data_one_access = 0, port_b_alt_data_two_access = 0;
    logic strobe_warning_read = 0, port_a_input_strobe, port_b_input_strobe;
    logic [7:0] port_c_function_select = '0, port_c_direction = '0, port_a_pins = '0;
    logic [7:0] port_a_strobe_control = '0, port_b_strobe_control = '0, lat;
    logic [7:0] port_a_direction = 8'h0f, port_a_output_latch = 8'ha5;
    logic [7:0] port_a_read_data, strobe_status, strobe_warning;
    logic port_a_bidir_strobe_o, port_a_bidir_strobe_oe, irq_n_o, irq_n_oe;
    logic port_b_bidir_strobe_o, port_b_bidir_strobe_oe;
    // Released strobe pins rest high through their pull-ups.
    wire logic port_a_bidir_strobe_i = port_a_bidir_strobe_oe ? port_a_bidir_strobe_o : 1'b1;
    wire logic port_b_bidir_strobe_i = port_b_bidir_strobe_oe ? port_b_bidir_strobe_o : 1'b1;
    int bad_count = 0, tests_run = 0, st = 0, wr = 0, bf = 0, n;
    logic [31:0] seed = 32'hc087_b60c;
    phs_port_handshake u_dut (.*);
    phs_peer u_pa (.clk(clk), .go(go_a), .req_n(port_a_bidir_strobe_o), .idle(1'b1),
        .line(port_a_input_strobe));
    phs_peer u_pb (.clk(clk), .go(go_b), .req_n(1'b1), .idle(1'b0), .line(port_b_input_strobe));
    always #5 clk = ~clk;
    // Bus cycles of six clocks, edges kept off the clock edge.
    initial begin
        #6;
        forever #30 address_strobe = ~address_strobe;
    end
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tick(int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic strike(ref logic s);
        s = 1;
        tick();
        s = 0;
        tick();
    endtask
    task automatic wait_lvl(ref logic s, input logic v);
        for (int i = 0; i < 12 && s !== v; i++) tick();
    endtask
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Model: an active edge sets status, or warning when status is already set.
    task automatic hit(int b, int irq);
        if (st[b]) wr[b] = 1;
        st[b] = 1;
        if (irq) st[7] = 1;
    endtask
    // Model: an access clears status and buffers warning; only line 0 uses irq here.
    task automatic clr(int b);
        bf[b] = wr[b];
        st[b] = 0;
        st[7] = st[0];
    endtask
    task automatic pulse_a();
        strike(go_a);
        tick(3);
        hit(0, 1);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // The scenarios need about 75 cycles; twenty times that means a hang.
    initial begin
        #15000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        tick(8);
        rst_n = 1;
        chk(strobe_status | strobe_warning, 8'h00);
        chk({port_a_bidir_strobe_o, port_b_bidir_strobe_o}, 8'h03);
        port_c_function_select = 8'hf0;
        port_c_direction = 8'ha0;
        port_a_strobe_control = 8'h01;
        port_b_strobe_control = 8'h0a;
        tick(2);
        for (int i = 0; i < 2; i++) begin
            pulse_a();
            chk(strobe_status, st[7:0]);
            chk(strobe_warning, wr[7:0]);
        end
        strike(strobe_warning_read);
        chk(strobe_warning, wr[7:0]);
        strike(port_a_alt_data_one_access);
        clr(0);
        chk({irq_n_oe, strobe_status[6:0]}, {1'b0, st[6:0]});
        chk(port_a_bidir_strobe_o, 8'h00);
        wait_lvl(port_a_bidir_strobe_o, 1'b1);
        chk(port_a_bidir_strobe_o, 8'h01);
        tick(3);
        hit(0, 1);
        strike(strobe_warning_read);
        wr = wr & ~bf;
        chk(strobe_warning, wr[7:0]);
        port_a_strobe_control = 8'h1d;
        strike(port_a_alt_data_one_access);
        clr(0);
        chk(port_a_bidir_strobe_o, 8'h01);
        seed = lfsr(seed);
        port_a_pins = seed[7:0];
        tick(2);
        chk(port_a_read_data, {port_a_pins[7:4], 4'h5});
        lat = port_a_pins;
        pulse_a();
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            port_a_pins = seed[7:0];
            tick(2);
            chk(port_a_read_data, {lat[7:4], 4'h5});
            if (i == 0) pulse_a();
        end
        chk(strobe_warning, wr[7:0]);
        strike(port_a_alt_data_one_access);
        clr(0);
        tick();
        chk(port_a_read_data, {port_a_pins[7:4], 4'h5});
        strike(go_b);
        tick(3);
        hit(2, 0);
        chk(strobe_status, st[7:0]);
        access_write = 1;
        strike(port_b_alt_data_one_access);
        access_write = 0;
        clr(2);
        chk(strobe_status, st[7:0]);
        wait_lvl(port_b_bidir_strobe_o, 1'b0);
        for (n = 0; n < 20 && port_b_bidir_strobe_o === 1'b0; n++) tick();
        chk({address_strobe, n[6:0]}, 8'h06);
        for (int m = 2; m < 4; m++) begin
            port_b_strobe_control = 8'h02 | 8'(m << 3);
            tick(2);
            chk(port_b_bidir_strobe_o, 8'(m - 2));
        end
        port_c_function_select = 8'hd0;
        port_c_direction = 8'ha0;
        tick();
        chk({port_a_bidir_strobe_oe, port_b_bidir_strobe_oe}, 8'h01);
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
